//--- design/pmurc_rail_regs.sv
// serial-port register bank for three buck rails
`include "pmurc_params.svh"

module pmurc_rail_regs
    import pmurc_pkg::*;
#(
    parameter bit VARIANT_A = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic serial_in_i,
    input wire logic core_rail_level_select_pin_i,
    input wire logic rail_two_level_select_pin_i,
    input wire logic standby_i,
    input wire logic core_rail_on_i,
    output logic serial_out_o,
    output logic serial_out_oe_n_o,
    output logic [6:0] core_rail_code_o,
    output logic [11:0] core_rail_mv_o,
    output logic [5:0] rail_one_code_o,
    output logic [11:0] rail_one_mv_o,
    output logic [5:0] rail_two_code_o,
    output logic [11:0] rail_two_mv_o,
    output logic rail_one_forced_pwm_o,
    output logic rail_two_forced_pwm_o,
    output logic core_rail_forced_pwm_o,
    output logic rail_one_enable_o,
    output logic rail_two_enable_o
);

    // ----------------------------------------------------------------
    // pin synchronisers and start-up
    // ----------------------------------------------------------------
    // bits: 0 cs_n, 1 sclk, 2 data in, 3 core pin, 4 rail two pin, 5 standby, 6 on
    logic [6:0] sync1_q, sync2_q;
    logic sclk3_q;
    logic [1:0] init_q, init_d;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 7'h01;
            sync2_q <= 7'h01;
            sclk3_q <= 1'h0;
            init_q <= 2'h0;
        end else begin
            sync1_q <= {core_rail_on_i, standby_i, rail_two_level_select_pin_i,
                        core_rail_level_select_pin_i, serial_in_i, spi_sclk_i, spi_cs_n_i};
            sync2_q <= sync1_q;
            sclk3_q <= sync2_q[1];
            init_q <= init_d;
        end
    end

    always_comb begin
        init_d = (init_q == `PMURC_INIT_DONE) ? init_q : init_q + 2'h1;
    end

    logic init_done, strap_load, cs_act, sclk_rise, sclk_fall, mosi;
    assign init_done = (init_q == `PMURC_INIT_DONE);
    assign strap_load = (init_q == `PMURC_INIT_STRAP);
    assign cs_act = ~sync2_q[0] & init_done;
    assign sclk_rise = sync2_q[1] & ~sclk3_q;
    assign sclk_fall = ~sync2_q[1] & sclk3_q;
    assign mosi = sync2_q[2];

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    pmurc_regs_type regs_q, regs_d;
    logic status_q, status_d;

    function automatic logic [7:0] rd_byte(input logic [6:0] a, input pmurc_regs_type r,
                                           input logic st);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `PMURC_ADDR_CORE_RAIL_VOLTAGE: v = {1'h0, r.core};
            `PMURC_ADDR_RAIL_ONE_VOLTAGE: v = {2'h0, r.one};
            `PMURC_ADDR_RAIL_TWO_VOLTAGE: v = {2'h0, r.two};
            `PMURC_ADDR_CORE_RAIL_STANDBY_VOLTAGE: v = {1'h0, r.stby};
            `PMURC_ADDR_RAIL_CONTROL: v = {st, 2'h0, r.fpwm, r.en};
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ----------------------------------------------------------------
    // serial frame and registers
    // ----------------------------------------------------------------
    pmurc_phase_type phase_q, phase_d;
    logic [2:0] cnt_q, cnt_d;
    logic [6:0] shift_q, shift_d;
    logic [6:0] addr_q, addr_d;
    logic rw_q, rw_d;
    logic [7:0] tx_q, tx_d;
    logic out_q, out_d, oe_n_q, oe_n_d;
    logic wr_fire;
    logic [7:0] wr_data;

    assign wr_fire = cs_act && phase_q == PH_DATA && sclk_rise && cnt_q == `PMURC_LAST_BIT
                     && !rw_q;
    assign wr_data = {shift_q, mosi};

    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        rw_d = rw_q;
        tx_d = tx_q;
        out_d = out_q;
        oe_n_d = oe_n_q;
        regs_d = regs_q;
        status_d = init_done ? sync2_q[6] : status_q;
        if (strap_load) begin
            regs_d.core = sync2_q[3] ? `PMURC_CORE_RST_HI : `PMURC_CORE_RST_LO;
            regs_d.stby = sync2_q[3] ? `PMURC_STBY_RST_HI : `PMURC_STBY_RST_LO;
            regs_d.two = !sync2_q[4] ? `PMURC_TWO_RST_LO :
                         VARIANT_A ? `PMURC_TWO_RST_HI_VARIANT : `PMURC_TWO_RST_HI;
        end
        if (!cs_act) begin
            phase_d = PH_IDLE;
            oe_n_d = 1'h1;
            out_d = 1'h0;
        end else begin
            case (phase_q)
                PH_IDLE: begin
                    phase_d = PH_CMD;
                    cnt_d = 3'h0;
                    shift_d = 7'h00;
                    tx_d = 8'h00;
                    oe_n_d = 1'h0;
                end
                PH_CMD: begin
                    if (sclk_rise) begin
                        shift_d = {shift_q[5:0], mosi};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == `PMURC_LAST_BIT) begin
                            phase_d = PH_DATA;
                            rw_d = shift_q[6];
                            addr_d = {shift_q[5:0], mosi};
                            tx_d = shift_q[6] ? rd_byte({shift_q[5:0], mosi}, regs_q, status_q)
                                              : 8'h00;
                        end
                    end
                end
                PH_DATA: begin
                    if (sclk_rise) begin
                        shift_d = {shift_q[5:0], mosi};
                        cnt_d = cnt_q + 3'h1;
                        if (cnt_q == `PMURC_LAST_BIT) begin
                            phase_d = PH_DONE;
                        end
                    end
                end
                PH_DONE: begin
                    phase_d = PH_DONE;
                end
                default: phase_d = PH_IDLE;
            endcase
            if (sclk_fall) begin
                out_d = tx_q[7];
                tx_d = {tx_q[6:0], 1'h0};
            end
        end
        if (wr_fire) begin
            case (addr_q)
                `PMURC_ADDR_CORE_RAIL_VOLTAGE: regs_d.core = wr_data[6:0];
                `PMURC_ADDR_RAIL_ONE_VOLTAGE: regs_d.one = wr_data[5:0];
                `PMURC_ADDR_RAIL_TWO_VOLTAGE: regs_d.two = wr_data[5:0];
                `PMURC_ADDR_CORE_RAIL_STANDBY_VOLTAGE: regs_d.stby = wr_data[6:0];
                `PMURC_ADDR_RAIL_CONTROL: begin
                    regs_d.fpwm = wr_data[`PMURC_CTRL_FPWM_LSB +: 3];
                    regs_d.en = wr_data[`PMURC_CTRL_EN_LSB +: 2];
                end
                default: regs_d = regs_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // rail outputs
    // ----------------------------------------------------------------
    logic [6:0] core_sel_d;
    logic [11:0] core_mv_d, one_mv_d, two_mv_d;

    always_comb begin
        core_sel_d = sync2_q[5] ? regs_q.stby : regs_q.core;
        core_mv_d = `PMURC_CORE_MV_BASE + `PMURC_CORE_MV_STEP * {5'h00, core_sel_d};
        one_mv_d = (regs_q.one >= `PMURC_RAIL_SAT_CODE) ? `PMURC_RAIL_MV_MAX :
                   `PMURC_RAIL_MV_BASE + `PMURC_RAIL_MV_STEP * {6'h00, regs_q.one};
        two_mv_d = (regs_q.two >= `PMURC_RAIL_SAT_CODE) ? `PMURC_RAIL_MV_MAX :
                   `PMURC_RAIL_MV_BASE + `PMURC_RAIL_MV_STEP * {6'h00, regs_q.two};
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase_q <= PH_IDLE;
            cnt_q <= 3'h0;
            shift_q <= 7'h00;
            addr_q <= 7'h00;
            rw_q <= 1'h0;
            tx_q <= 8'h00;
            out_q <= 1'h0;
            oe_n_q <= 1'h1;
            regs_q <= '{core: `PMURC_CORE_RST_HI, one: `PMURC_ONE_RST, two: `PMURC_TWO_RST_HI,
                        stby: `PMURC_STBY_RST_HI, fpwm: `PMURC_FPWM_RST, en: `PMURC_EN_RST};
            status_q <= `PMURC_STATUS_RST;
            core_rail_code_o <= `PMURC_CORE_RST_HI;
            core_rail_mv_o <= 12'h000;
            rail_one_mv_o <= 12'h000;
            rail_two_mv_o <= 12'h000;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            rw_q <= rw_d;
            tx_q <= tx_d;
            out_q <= out_d;
            oe_n_q <= oe_n_d;
            regs_q <= regs_d;
            status_q <= status_d;
            core_rail_code_o <= core_sel_d;
            core_rail_mv_o <= core_mv_d;
            rail_one_mv_o <= one_mv_d;
            rail_two_mv_o <= two_mv_d;
        end
    end

    assign serial_out_o = out_q;
    assign serial_out_oe_n_o = oe_n_q;
    assign rail_one_code_o = regs_q.one;
    assign rail_two_code_o = regs_q.two;
    assign rail_one_forced_pwm_o = regs_q.fpwm[2];
    assign rail_two_forced_pwm_o = regs_q.fpwm[1];
    assign core_rail_forced_pwm_o = regs_q.fpwm[0];
    assign rail_one_enable_o = regs_q.en[1];
    assign rail_two_enable_o = regs_q.en[0];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_core_code_write: assert property (
        wr_fire && addr_q == `PMURC_ADDR_CORE_RAIL_VOLTAGE |=> regs_q.core == $past(wr_data[6:0]))
        else $error("core code write lost");
    a_core_strap_load: assert property (
        strap_load |=> regs_q.core == ($past(sync2_q[3]) ? 7'h64 : 7'h3c))
        else $error("core code strap default wrong");
    a_rail_one_write: assert property (
        wr_fire && addr_q == `PMURC_ADDR_RAIL_ONE_VOLTAGE
        |=> rail_one_code_o == $past(wr_data[5:0]))
        else $error("rail one write lost");
    a_rail_two_strap: assert property (
        strap_load |=> regs_q.two == (!$past(sync2_q[4]) ? 6'h0e : VARIANT_A ? 6'h12 : 6'h26))
        else $error("rail two strap default wrong");
    a_standby_strap: assert property (
        strap_load |=> regs_q.stby == ($past(sync2_q[3]) ? 7'h53 : 7'h2e))
        else $error("standby strap default wrong");
    a_ctrl_enable_write: assert property (
        wr_fire && addr_q == `PMURC_ADDR_RAIL_CONTROL
        |=> rail_one_enable_o == $past(wr_data[1]) && rail_two_enable_o == $past(wr_data[0]))
        else $error("rail enable write lost");
    a_ctrl_pwm_write: assert property (
        wr_fire && addr_q == `PMURC_ADDR_RAIL_CONTROL
        |=> rail_one_forced_pwm_o == $past(wr_data[4])
        && rail_two_forced_pwm_o == $past(wr_data[3])
        && core_rail_forced_pwm_o == $past(wr_data[2]))
        else $error("forced pwm write lost");
    a_rail_one_mv: assert property (
        !$past(sys_rst_i) |-> rail_one_mv_o == (($past(regs_q.one) >= 6'h32) ? 12'he10
                              : 12'h44c + 12'h032 * {6'h00, $past(regs_q.one)}))
        else $error("rail one voltage mapping wrong");
    a_core_mv_map: assert property (
        !$past(sys_rst_i) |-> core_rail_mv_o == 12'h2bc + 12'h005 * {5'h00, core_rail_code_o})
        else $error("core voltage mapping wrong");
    a_standby_select: assert property (
        sync2_q[5] && $stable(regs_q.stby) |=> core_rail_code_o == $past(regs_q.stby))
        else $error("standby code not presented");
    a_unused_bits_zero: assert property (
        phase_q == PH_CMD && phase_d == PH_DATA && rw_d
        && addr_d == `PMURC_ADDR_RAIL_ONE_VOLTAGE |=> tx_q[7:6] == 2'h0)
        else $error("unused bits not zero");
    a_out_enable: assert property (
        cs_act && phase_q != PH_IDLE |-> !serial_out_oe_n_o)
        else $error("serial out not driven in frame");

    c_write_frame: cover property (wr_fire);
    c_read_frame: cover property (phase_q == PH_CMD ##1 phase_q == PH_DATA && rw_q);
    c_standby: cover property (sync2_q[5] && init_done);

endmodule // pmurc_rail_regs

//--- inc/pmurc_params.svh
// offsets, reset values and constants of the rail control register bank
`ifndef PMURC_PARAMS_SVH
`define PMURC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PMURC_ADDR_CORE_RAIL_VOLTAGE 7'h00
`define PMURC_ADDR_RAIL_ONE_VOLTAGE 7'h07
`define PMURC_ADDR_RAIL_TWO_VOLTAGE 7'h08
`define PMURC_ADDR_CORE_RAIL_STANDBY_VOLTAGE 7'h09
`define PMURC_ADDR_RAIL_CONTROL 7'h0a

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMURC_CORE_RST_HI 7'h64
`define PMURC_CORE_RST_LO 7'h3c
`define PMURC_ONE_RST 6'h26
`define PMURC_TWO_RST_HI 6'h26
`define PMURC_TWO_RST_HI_VARIANT 6'h12
`define PMURC_TWO_RST_LO 6'h0e
`define PMURC_STBY_RST_HI 7'h53
`define PMURC_STBY_RST_LO 7'h2e
`define PMURC_FPWM_RST 3'h0
`define PMURC_EN_RST 2'h1
`define PMURC_STATUS_RST 1'h1

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PMURC_CTRL_STATUS_BIT 7
`define PMURC_CTRL_FPWM_LSB 2
`define PMURC_CTRL_EN_LSB 0

// ----------------------------------------------------------------
// voltage mapping in millivolts
// ----------------------------------------------------------------
`define PMURC_RAIL_MV_BASE 12'h44c
`define PMURC_RAIL_MV_STEP 12'h032
`define PMURC_RAIL_MV_MAX 12'he10
`define PMURC_RAIL_SAT_CODE 6'h32
`define PMURC_CORE_MV_BASE 12'h2bc
`define PMURC_CORE_MV_STEP 12'h005

// ----------------------------------------------------------------
// frame and start-up counts
// ----------------------------------------------------------------
`define PMURC_LAST_BIT 3'h7
`define PMURC_INIT_STRAP 2'h2
`define PMURC_INIT_DONE 2'h3

`endif

//--- inc/pmurc_pkg.sv
// types of the rail control register bank
package pmurc_pkg;

    typedef struct packed {
        logic [6:0] core;
        logic [5:0] one;
        logic [5:0] two;
        logic [6:0] stby;
        logic [2:0] fpwm;
        logic [1:0] en;
    } pmurc_regs_type;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CMD,
        PH_DATA,
        PH_DONE
    } pmurc_phase_type;

endpackage

//--- tb/pmurc_host_model.sv
// serial link master model driving the rail control register bank
module pmurc_host_model
    import pmurc_pkg::*;
(
    input wire logic clk_i,
    input wire logic miso_i,
    input wire logic oe_n_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    logic oe_seen;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        oe_seen = 1'b1;
    end

    // ------------------------------------------------------------
    // frame transfer
    // ------------------------------------------------------------
    // four-wire master frame
    task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            repeat (2) @(posedge clk_i);
            mosi_o <= word[15 - i];
            repeat (3) @(posedge clk_i);
            if (i >= 8) rd = {rd[6:0], miso_i};
            if (i == 8) oe_seen = oe_n_i;
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // released data line no longer shows last bit
        mosi_o <= ~mosi_o;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // pmurc_host_model

//--- tb/tb_pmurc_rail_regs.sv
// self-checking bench for the rail control register bank
`include "pmurc_params.svh"

module tb_pmurc_rail_regs
    import pmurc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk_i, sys_rst_i, spi_cs_n_i, spi_sclk_i, serial_in_i, standby_i, core_rail_on_i;
    logic core_rail_level_select_pin_i, rail_two_level_select_pin_i;
    logic serial_out_o, serial_out_oe_n_o, rail_one_forced_pwm_o, rail_two_forced_pwm_o;
    logic core_rail_forced_pwm_o, rail_one_enable_o, rail_two_enable_o;
    logic [6:0] core_rail_code_o;
    logic [5:0] rail_one_code_o, rail_two_code_o;
    logic [11:0] core_rail_mv_o, rail_one_mv_o, rail_two_mv_o;
    int error_cnt = 0;
    int n_tests = 0;

    pmurc_rail_regs #(.VARIANT_A(1'b0)) dut (.clk_i, .sys_rst_i, .spi_cs_n_i, .spi_sclk_i,
        .serial_in_i, .core_rail_level_select_pin_i, .rail_two_level_select_pin_i, .standby_i,
        .core_rail_on_i, .serial_out_o, .serial_out_oe_n_o, .core_rail_code_o, .core_rail_mv_o,
        .rail_one_code_o, .rail_one_mv_o, .rail_two_code_o, .rail_two_mv_o,
        .rail_one_forced_pwm_o, .rail_two_forced_pwm_o, .core_rail_forced_pwm_o,
        .rail_one_enable_o, .rail_two_enable_o);

    pmurc_host_model host (.clk_i, .miso_i(serial_out_o), .oe_n_i(serial_out_oe_n_o),
        .cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i), .mosi_o(serial_in_i));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [11:0] rail_mv(input logic [5:0] c);
        return (c >= 6'h32) ? 12'he10 : 12'h44c + 12'h032 * {6'h00, c};
    endfunction

    function automatic logic [11:0] core_mv(input logic [6:0] c);
        return 12'h2bc + 12'h005 * {5'h00, c};
    endfunction

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rd;
        host.xfer({1'b0, a, d}, 16, rd);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.xfer({1'b1, a, 8'h00}, 16, d);
        check({4'h0, d}, {4'h0, exp}, "register read");
    endtask

    task automatic chk_ctl(input logic [4:0] k);
        check({7'h00, rail_one_forced_pwm_o, rail_two_forced_pwm_o, core_rail_forced_pwm_o,
            rail_one_enable_o, rail_two_enable_o}, {7'h00, k}, "control outputs");
    endtask

    task automatic chk_outs(input logic [6:0] c, input logic [5:0] o, input logic [5:0] t);
        check({5'h00, core_rail_code_o}, {5'h00, c}, "core code");
        check(core_rail_mv_o, core_mv(c), "core mv");
        check({6'h00, rail_one_code_o}, {6'h00, o}, "one code");
        check(rail_one_mv_o, rail_mv(o), "one mv");
        check({6'h00, rail_two_code_o}, {6'h00, t}, "two code");
        check(rail_two_mv_o, rail_mv(t), "two mv");
    endtask

    task automatic do_reset(input logic core_hi, input logic two_hi);
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        core_rail_on_i <= 1'b1;
        core_rail_level_select_pin_i <= core_hi;
        rail_two_level_select_pin_i <= two_hi;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] v;
        logic [7:0] d;
        sys_rst_i = 1'b1;
        standby_i = 1'b0;
        core_rail_on_i = 1'b1;
        core_rail_level_select_pin_i = 1'b1;
        rail_two_level_select_pin_i = 1'b1;
        do_reset(1'b1, 1'b1);
        chk_outs(7'h64, 6'h26, 6'h26);
        chk_ctl(5'h01);
        check({11'h000, serial_out_oe_n_o}, 12'h001, "idle oe");
        rd_chk(`PMURC_ADDR_CORE_RAIL_VOLTAGE, 8'h64);
        rd_chk(`PMURC_ADDR_RAIL_ONE_VOLTAGE, 8'h26);
        rd_chk(`PMURC_ADDR_RAIL_TWO_VOLTAGE, 8'h26);
        rd_chk(`PMURC_ADDR_CORE_RAIL_STANDBY_VOLTAGE, 8'h53);
        rd_chk(`PMURC_ADDR_RAIL_CONTROL, 8'h81);
        check({11'h000, host.oe_seen}, 12'h000, "oe in frame");
        // unused bits written high
        reg_wr(7'h00, 8'hff);
        reg_wr(7'h07, 8'hff);
        reg_wr(7'h08, 8'hc0);
        reg_wr(7'h09, 8'hae);
        chk_outs(7'h7f, 6'h3f, 6'h00);
        rd_chk(7'h00, 8'h7f);
        rd_chk(7'h07, 8'h3f);
        rd_chk(7'h08, 8'h00);
        rd_chk(7'h09, 8'h2e);
        // saturation boundary
        for (int i = 0; i < 3; i++) begin
            reg_wr(7'h07, 8'h31 + i[7:0]);
            check(rail_one_mv_o, rail_mv(6'h31 + i[5:0]), "one mv edge");
        end
        // standby substitution
        reg_wr(7'h00, 8'h00);
        standby_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({5'h00, core_rail_code_o}, 12'h02e, "standby code");
        check(core_rail_mv_o, core_mv(7'h2e), "standby mv");
        standby_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk_outs(7'h00, 6'h33, 6'h00);
        // control bits one at a time, then all set together
        for (int i = 0; i < 6; i++) begin
            v = (i == 5) ? 8'hff : (8'h01 << i);
            reg_wr(7'h0a, v);
            chk_ctl(v[4:0]);
            rd_chk(7'h0a, {3'h4, v[4:0]});
        end
        core_rail_on_i <= 1'b0;
        reg_wr(7'h0a, 8'h00);
        chk_ctl(5'h00);
        rd_chk(7'h0a, 8'h00);
        // unmapped and short frames
        reg_wr(7'h05, 8'haa);
        rd_chk(7'h05, 8'h00);
        host.xfer({1'b0, 7'h07, 8'h11}, 12, d);
        rd_chk(7'h07, 8'h33);
        // low straps
        do_reset(1'b0, 1'b0);
        chk_outs(7'h3c, 6'h26, 6'h0e);
        rd_chk(7'h09, 8'h2e);
        rd_chk(7'h0a, 8'h81);
        close_out();
    end
endmodule // tb_pmurc_rail_regs
